// File: rtl/pisr_consts.svh
`ifndef PISR_CONSTS_SVH
`define PISR_CONSTS_SVH

// command codes
`define PISR_CODE_CAPABILITY 8'h19
`define PISR_CODE_REVISION 8'h98
`define PISR_CODE_GUI_A 8'hb0
`define PISR_CODE_GUI_B 8'hb1
`define PISR_CODE_OEM 8'hb2
`define PISR_CODE_PAGED_SCRATCH 8'hb3
`define PISR_CODE_UNPAGED_SCRATCH 8'hb4
`define PISR_CODE_MAKER_RSV_A 8'hb5
`define PISR_CODE_MAKER_INFO 8'hb6
`define PISR_CODE_MAKER_RSV_B 8'hbc
`define PISR_CODE_MAKER_IDENTITY 8'he7
`define PISR_CODE_FACTORY_LOT 8'he8

// capability fields and values
`define PISR_CAP_PEC_BIT 7
`define PISR_CAP_SCL_MSB 6
`define PISR_CAP_SCL_LSB 5
`define PISR_CAP_SCL_400K 2'h1
`define PISR_CAP_ALERT_BIT 4
`define PISR_CAP_RESET 8'hb0
`define PISR_REVISION_RESET 8'h11

// information word
`define PISR_INFO_ECC_BIT 5
`define PISR_INFO_RESET 16'h0000

// scratch bank slot map
`define PISR_SLOT_GUI_A 5'h00
`define PISR_SLOT_OEM 5'h01
`define PISR_SLOT_UNPAGED_SCRATCH 5'h02
`define PISR_BASE_GUI_B 3'h1
`define PISR_BASE_PAGED_SCRATCH 3'h2
`define PISR_BASE_MAKER_RSV_A 3'h3
`define PISR_BASE_LOT 3'h4
`define PISR_BASE_MAKER_RSV_B 3'h5
`define PISR_BANK_DEPTH 24
`define PISR_SLOT_VOLATILE 5'h14
`define PISR_SCRATCH_RESET 16'h0000

// fault log readout tail
`define PISR_FAULT_LAST_VALID 8'hed
`define PISR_FAULT_FINAL 8'hff
`define PISR_FAULT_PAD 8'h00

`endif

// File: rtl/pisr_fault_tail.sv
`timescale 1ns/10ps
`default_nettype none
`include "pisr_consts.svh"

module pisr_fault_tail (
	input wire logic core_clk, // core clock
	input wire logic rst, // async reset, active high
	input wire logic rd_valid, // host reads one log byte
	input wire logic [7:0] rd_index, // byte position in the block
	input wire logic [7:0] src_byte, // byte from the log store
	input wire logic set_present, // log logic captured a new log
	output logic [7:0] out_byte, // byte returned to host
	output logic out_valid, // out_byte valid pulse
	output logic present // log present flag
);

	logic [7:0] byte_r, byte_nxt;
	logic valid_r, valid_nxt;
	logic present_r, present_nxt;

	always_comb begin
		byte_nxt = src_byte;
		if (rd_index > `PISR_FAULT_LAST_VALID) begin
			byte_nxt = `PISR_FAULT_PAD;
		end
		valid_nxt = rd_valid;
		present_nxt = present_r;
		if (rd_valid && rd_index == `PISR_FAULT_FINAL) begin
			present_nxt = 1'h0;
		end
		// a new log in the same cycle must not be lost
		if (set_present) begin
			present_nxt = 1'h1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			byte_r <= 8'h00;
			valid_r <= 1'h0;
			present_r <= 1'h0;
		end else begin
			byte_r <= byte_nxt;
			valid_r <= valid_nxt;
			present_r <= present_nxt;
		end
	end

	assign out_byte = byte_r;
	assign out_valid = valid_r;
	assign present = present_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_tail_pad_zero: assert property (rd_valid && rd_index > 8'hed |=> out_valid && out_byte == 8'h00)
		else $error("padding byte not zero");
	a_tail_pass_data: assert property (rd_valid && rd_index <= 8'hed |=> out_byte == $past(src_byte))
		else $error("valid log byte altered");
	a_flag_final_clear: assert property (rd_valid && rd_index == 8'hff && !set_present |=> !present)
		else $error("flag not cleared by final byte");
	a_flag_hold_other: assert property (present && !set_present && !(rd_valid && rd_index == 8'hff) |=> present)
		else $error("flag cleared without final byte");
	a_flag_set_wins: assert property (set_present |=> present)
		else $error("new log lost");

endmodule : pisr_fault_tail
`default_nettype wire

// File: rtl/pisr_pkg.sv
package pisr_pkg;

	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] page;
		logic [7:0] code;
		logic [15:0] wdata;
	} pisr_req_type;

	typedef struct packed {
		logic valid;
		logic ack;
		logic word;
		logic [15:0] data;
	} pisr_rsp_type;

	typedef struct packed {
		logic valid;
		logic [4:0] target;
		logic [15:0] data;
	} pisr_ee_load_type;

endpackage : pisr_pkg

// File: rtl/pisr_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "pisr_consts.svh"

module pisr_regs
	import pisr_pkg::*;
#(
	parameter logic [15:0] MAKER_IDENTITY = 16'h5a3c // arbitrary value
) (
	input wire logic core_clk, // core clock
	input wire logic rst, // async reset, active high
	input wire pisr_req_type req, // command access
	output var pisr_rsp_type rsp, // command answer
	input wire pisr_ee_load_type ee_load, // eeprom image word
	input wire logic restore_all, // restore-all command pulse
	input wire logic bulk_read, // eeprom bulk read done pulse
	input wire logic ecc_clean, // no ecc corrections in user space
	input wire logic pec_cfg_en, // global checking enable
	output logic pec_required, // checking currently required
	input wire logic fl_rd_valid, // fault log byte read
	input wire logic [7:0] fl_rd_index, // fault log byte position
	input wire logic [7:0] fl_src_byte, // fault log stored byte
	input wire logic fl_set_present, // new fault log captured
	output logic [7:0] fl_byte, // fault log byte to host
	output logic fl_byte_valid, // fault log byte pulse
	output logic fault_log_present // fault log present flag
);

	logic [7:0] cap_byte;
	logic [15:0] info_r, info_nxt;
	logic por_pending_r, por_pending_nxt;
	logic pec_r, pec_nxt;
	pisr_rsp_type rsp_r, rsp_nxt;

	logic hit;
	logic writable;
	logic is_word;
	logic use_bank;
	logic [4:0] slot;
	logic [15:0] fixed_data;
	logic [15:0] bank_data;
	logic bank_wr;
	logic refresh;

	// capability assembled from its fields
	always_comb begin
		cap_byte = 8'h00;
		cap_byte[`PISR_CAP_PEC_BIT] = 1'h1;
		cap_byte[`PISR_CAP_SCL_MSB:`PISR_CAP_SCL_LSB] = `PISR_CAP_SCL_400K;
		cap_byte[`PISR_CAP_ALERT_BIT] = 1'h1;
	end

	// command decode
	always_comb begin
		hit = 1'h1;
		writable = 1'h0;
		is_word = 1'h1;
		use_bank = 1'h0;
		slot = 5'h00;
		fixed_data = 16'h0000;
		unique case (req.code)
			`PISR_CODE_CAPABILITY: begin
				is_word = 1'h0;
				fixed_data = {8'h00, cap_byte};
			end
			`PISR_CODE_REVISION: begin
				is_word = 1'h0;
				fixed_data = {8'h00, `PISR_REVISION_RESET};
			end
			`PISR_CODE_MAKER_IDENTITY: begin
				fixed_data = MAKER_IDENTITY;
			end
			`PISR_CODE_MAKER_INFO: begin
				fixed_data = info_r;
			end
			`PISR_CODE_FACTORY_LOT: begin
				is_word = 1'h0;
				use_bank = 1'h1;
				slot = {`PISR_BASE_LOT, req.page};
			end
			`PISR_CODE_GUI_A: begin
				writable = 1'h1;
				use_bank = 1'h1;
				slot = `PISR_SLOT_GUI_A;
			end
			`PISR_CODE_GUI_B: begin
				writable = 1'h1;
				use_bank = 1'h1;
				slot = {`PISR_BASE_GUI_B, req.page};
			end
			`PISR_CODE_OEM: begin
				writable = 1'h1;
				use_bank = 1'h1;
				slot = `PISR_SLOT_OEM;
			end
			`PISR_CODE_PAGED_SCRATCH: begin
				writable = 1'h1;
				use_bank = 1'h1;
				slot = {`PISR_BASE_PAGED_SCRATCH, req.page};
			end
			`PISR_CODE_UNPAGED_SCRATCH: begin
				writable = 1'h1;
				use_bank = 1'h1;
				slot = `PISR_SLOT_UNPAGED_SCRATCH;
			end
			`PISR_CODE_MAKER_RSV_A: begin
				writable = 1'h1;
				use_bank = 1'h1;
				slot = {`PISR_BASE_MAKER_RSV_A, req.page};
			end
			`PISR_CODE_MAKER_RSV_B: begin
				writable = 1'h1;
				use_bank = 1'h1;
				slot = {`PISR_BASE_MAKER_RSV_B, req.page};
			end
			default: begin
				hit = 1'h0;
			end
		endcase
	end

	// read-only codes are acknowledged but never stored
	assign bank_wr = req.valid && req.write && writable;

	pisr_word_bank u_bank (
		.core_clk(core_clk),
		.rst(rst),
		.wr_en(bank_wr),
		.wr_slot(slot),
		.wr_data(req.wdata),
		.ee(ee_load),
		.rd_slot(slot),
		.rd_data(bank_data)
	);

	// response, one cycle after the request
	always_comb begin
		rsp_nxt = '0;
		rsp_nxt.valid = req.valid;
		rsp_nxt.ack = req.valid && hit;
		rsp_nxt.word = is_word;
		if (req.valid && hit && !req.write) begin
			if (use_bank) begin
				rsp_nxt.data = is_word ? bank_data : {8'h00, bank_data[7:0]};
			end else begin
				rsp_nxt.data = fixed_data;
			end
		end
	end

	// the reset value cannot be taken from a port, so the first
	// clock after release performs the power-on refresh
	assign refresh = por_pending_r || restore_all || bulk_read;

	always_comb begin
		por_pending_nxt = 1'h0;
		info_nxt = info_r;
		if (refresh) begin
			info_nxt = `PISR_INFO_RESET;
			info_nxt[`PISR_INFO_ECC_BIT] = ecc_clean;
		end
		pec_nxt = pec_cfg_en;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rsp_r <= '0;
			info_r <= `PISR_INFO_RESET;
			por_pending_r <= 1'h1;
			pec_r <= 1'h0;
		end else begin
			rsp_r <= rsp_nxt;
			info_r <= info_nxt;
			por_pending_r <= por_pending_nxt;
			pec_r <= pec_nxt;
		end
	end

	assign rsp = rsp_r;
	assign pec_required = pec_r;

	pisr_fault_tail u_tail (
		.core_clk(core_clk),
		.rst(rst),
		.rd_valid(fl_rd_valid),
		.rd_index(fl_rd_index),
		.src_byte(fl_src_byte),
		.set_present(fl_set_present),
		.out_byte(fl_byte),
		.out_valid(fl_byte_valid),
		.present(fault_log_present)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_read(logic [7:0] c);
		req.valid && !req.write && req.code == c;
	endsequence

	sequence s_write_unpaged;
		req.valid && req.write && req.code == 8'hb4;
	endsequence

	sequence s_write(logic [7:0] c);
		req.valid && req.write && req.code == c;
	endsequence

	// idle cycle keeps other writes and image loads out of a readback
	sequence s_gap;
		!req.valid && !ee_load.valid;
	endsequence

	sequence s_refresh_req;
		restore_all || bulk_read;
	endsequence

	a_cap_read_value: assert property (s_read(8'h19) |=> rsp.ack && !rsp.word && rsp.data == 16'h00b0)
		else $error("capability read wrong");
	a_cap_field_bits: assert property (s_read(8'h19) |=> rsp.data[7] && rsp.data[6:5] == 2'h1 && rsp.data[4])
		else $error("capability fields wrong");
	a_cap_low_zero: assert property (s_read(8'h19) |=> rsp.data[3:0] == 4'h0)
		else $error("capability reserved bits set");
	a_rev_read_value: assert property (s_read(8'h98) |=> rsp.ack && rsp.data == 16'h0011)
		else $error("revision read wrong");
	a_id_read_value: assert property (s_read(8'he7) |=> rsp.word && rsp.data == MAKER_IDENTITY)
		else $error("identity read wrong");
	a_pec_report_follow: assert property (##1 pec_required == $past(pec_cfg_en))
		else $error("checking enable not reported");
	a_info_refresh_ecc: assert property (s_refresh_req ##1 s_read(8'hb6) |=>
		rsp.data[5] == $past(ecc_clean, 2) && rsp.data[15:6] == 10'h000)
		else $error("info word not refreshed");
	a_info_ro_hold: assert property (!refresh |=> info_r == $past(info_r))
		else $error("info word changed without refresh");
	a_scratch_write_read: assert property (s_write_unpaged ##1 s_gap ##1 s_read(8'hb4)
		|=> rsp.data == $past(req.wdata, 3))
		else $error("scratch word not stored");
	a_unmapped_no_ack: assert property (req.valid && !hit |=> rsp.valid && !rsp.ack)
		else $error("unmapped code acknowledged");
	a_lot_byte_read: assert property (s_read(8'he8) |=> !rsp.word && rsp.data[15:8] == 8'h00)
		else $error("lot byte malformed");

	// answer framing
	a_rsp_follows_req: assert property (req.valid |=> rsp.valid)
		else $error("request not answered");
	a_rsp_idle_quiet: assert property (!req.valid |=> !rsp.valid && rsp.data == 16'h0000)
		else $error("answer without request");
	a_ack_mapped_code: assert property (req.valid && hit |=> rsp.ack)
		else $error("mapped code not acknowledged");
	a_write_no_data: assert property (req.valid && req.write |=> rsp.data == 16'h0000)
		else $error("write answer carries data");
	a_unmapped_zero: assert property (req.valid && !hit |=> rsp.data == 16'h0000)
		else $error("unmapped code returned data");
	a_rev_byte_kind: assert property (s_read(8'h98) |=> !rsp.word && rsp.data[15:8] == 8'h00)
		else $error("revision not a byte");
	a_ro_write_acked: assert property (req.valid && req.write &&
		req.code inside {8'h19, 8'h98, 8'hb6, 8'he7, 8'he8} |=> rsp.ack && rsp.data == 16'h0000)
		else $error("read-only write refused");

	// refresh paths
	a_info_fields: assert property (s_read(8'hb6) |=> rsp.word && rsp.data[4:0] == 5'h00)
		else $error("info reserved bits set");
	a_info_refresh_load: assert property (s_refresh_req |=>
		info_r == {10'h000, $past(ecc_clean), 5'h00})
		else $error("info word not reloaded");
	a_por_refresh_once: assert property (!rst && por_pending_r |=>
		!por_pending_r && info_r[5] == $past(ecc_clean))
		else $error("power-on refresh missing");

	// scratch and reserved words
	a_gui_a_kind: assert property (s_read(8'hb0) |=> rsp.ack && rsp.word)
		else $error("gui word a not a word");
	a_gui_b_kind: assert property (s_read(8'hb1) |=> rsp.ack && rsp.word)
		else $error("gui word b not a word");
	a_oem_kind: assert property (s_read(8'hb2) |=> rsp.ack && rsp.word)
		else $error("oem word not a word");
	a_rsv_a_kind: assert property (s_read(8'hb5) |=> rsp.ack && rsp.word)
		else $error("reserved word a not a word");
	a_rsv_b_kind: assert property (s_read(8'hbc) |=> rsp.ack && rsp.word)
		else $error("reserved word b not a word");
	a_scratch_kind: assert property (s_read(8'hb3) |=> rsp.ack && rsp.word)
		else $error("paged scratch not a word");
	a_unpaged_kind: assert property (s_read(8'hb4) |=> rsp.ack && rsp.word)
		else $error("unpaged scratch not a word");
	a_paged_write_read: assert property (s_write(8'hb3) ##1 s_gap ##1 s_read(8'hb3)
		|=> rsp.data == $past(req.wdata, 3) || $past(req.page) != $past(req.page, 3))
		else $error("paged scratch word not stored");

endmodule : pisr_regs
`default_nettype wire

// File: rtl/pisr_word_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "pisr_consts.svh"

module pisr_word_bank
	import pisr_pkg::*;
(
	input wire logic core_clk, // core clock
	input wire logic rst, // async reset, active high
	input wire logic wr_en, // host write strobe
	input wire logic [4:0] wr_slot, // host write slot
	input wire logic [15:0] wr_data, // host write data
	input wire pisr_ee_load_type ee, // eeprom image word
	input wire logic [4:0] rd_slot, // read slot
	output logic [15:0] rd_data // read data
);

	logic [15:0] mem_r [`PISR_BANK_DEPTH];
	logic [15:0] mem_nxt [`PISR_BANK_DEPTH];

	always_comb begin
		for (int i = 0; i < `PISR_BANK_DEPTH; i++) begin
			mem_nxt[i] = mem_r[i];
		end
		// slots from the volatile base up have no eeprom copy
		if (ee.valid && ee.target < `PISR_SLOT_VOLATILE) begin
			mem_nxt[ee.target] = ee.data;
		end
		// host write wins over a concurrent image load
		if (wr_en) begin
			mem_nxt[wr_slot] = wr_data;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `PISR_BANK_DEPTH; i++) begin
				mem_r[i] <= `PISR_SCRATCH_RESET;
			end
		end else begin
			for (int i = 0; i < `PISR_BANK_DEPTH; i++) begin
				mem_r[i] <= mem_nxt[i];
			end
		end
	end

	assign rd_data = mem_r[rd_slot];

endmodule : pisr_word_bank
`default_nettype wire

// File: rtl/unused_placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: tb/pisr_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module pisr_host_model
	import pisr_pkg::*;
(
	input wire logic core_clk, // core clock
	input wire pisr_rsp_type rsp, // device answer
	output var pisr_req_type req, // command access
	output logic fl_rd_valid, // log byte read
	output logic [7:0] fl_rd_index, // log byte position
	output logic [7:0] fl_src_byte // stored log byte
);
	initial begin
		req = '0;
		fl_rd_valid = 1'b0;
		fl_rd_index = 8'h00;
		fl_src_byte = 8'h00;
	end

	// released fields show the inverse so a stale value never reads as fresh
	task automatic access(input logic wr, input logic [1:0] pg, input logic [7:0] cd,
		input logic [15:0] wd, output pisr_rsp_type r);
		@(posedge core_clk);
		req <= '{1'b1, wr, pg, cd, wd};
		@(posedge core_clk);
		req <= '{1'b0, ~wr, ~pg, ~cd, ~wd};
		#1 r = rsp;
	endtask : access

	task automatic log_read(input logic [7:0] idx, input logic [7:0] src);
		@(posedge core_clk);
		fl_rd_valid <= 1'b1;
		fl_rd_index <= idx;
		fl_src_byte <= src;
		@(posedge core_clk);
		fl_rd_valid <= 1'b0;
		fl_rd_index <= ~idx;
		fl_src_byte <= ~src;
		#1;
	endtask : log_read
endmodule : pisr_host_model

`default_nettype wire

// File: tb/pisr_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module pisr_regs_tb_top
	import pisr_pkg::*;
;
	localparam logic [15:0] IDENT = 16'h1e2d; // arbitrary value
	logic core_clk, rst, restore_all, bulk_read, ecc_clean, pec_cfg_en, fl_set_present;
	logic fl_rd_valid, fl_byte_valid, fault_log_present, pec_required;
	logic [7:0] fl_rd_index, fl_src_byte, fl_byte;
	pisr_req_type req;
	pisr_rsp_type rsp, r;
	pisr_ee_load_type ee_load;
	int fail_count = 0;
	int tests_run = 0;
	logic [7:0] ro_code [4] = '{8'h19, 8'h98, 8'he7, 8'hb6};
	logic [15:0] ro_val [4] = '{16'h00b0, 16'h0011, IDENT, 16'h0020};
	logic [3:0] ro_word = 4'b1100;
	logic [7:0] rw_code [7] = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hbc};
	logic [6:0] rw_paged = 7'b1101010;

	pisr_regs #(.MAKER_IDENTITY(IDENT)) u_dut (.core_clk(core_clk), .rst(rst), .req(req),
		.rsp(rsp), .ee_load(ee_load), .restore_all(restore_all), .bulk_read(bulk_read),
		.ecc_clean(ecc_clean), .pec_cfg_en(pec_cfg_en), .pec_required(pec_required),
		.fl_rd_valid(fl_rd_valid), .fl_rd_index(fl_rd_index), .fl_src_byte(fl_src_byte),
		.fl_set_present(fl_set_present), .fl_byte(fl_byte), .fl_byte_valid(fl_byte_valid),
		.fault_log_present(fault_log_present));

	pisr_host_model u_host (.core_clk(core_clk), .rsp(rsp), .req(req),
		.fl_rd_valid(fl_rd_valid), .fl_rd_index(fl_rd_index), .fl_src_byte(fl_src_byte));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic chk_rsp(input pisr_rsp_type got, input logic ack, input logic wd,
		input logic [15:0] d);
		pisr_rsp_type exp;
		exp = '{1'b1, ack, wd, d};
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t answer %h expected %h", $time, got, exp);
		end
	endtask : chk_rsp

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic tally_and_finish();
		if (fail_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	task automatic t_ro(input logic wr);
		for (int i = 0; i < 4; i++) begin
			if (wr) begin
				u_host.access(1'b1, 2'h0, ro_code[i], 16'hffff, r);
				chk_val({15'h0000, r.ack}, 16'h0001);
			end
			u_host.access(1'b0, 2'h3, ro_code[i], 16'h0000, r);
			chk_rsp(r, 1'b1, ro_word[i], ro_val[i]);
		end
		u_host.access(1'b0, 2'h0, 8'h00, 16'h0000, r);
		chk_val({r.ack, r.data[14:0]}, 16'h0000);
	endtask : t_ro

	task automatic t_scratch();
		u_host.access(1'b0, 2'h1, 8'hb3, 16'h0000, r);
		chk_rsp(r, 1'b1, 1'b1, 16'h0000);
		u_host.access(1'b0, 2'h0, 8'hb4, 16'h0000, r);
		chk_rsp(r, 1'b1, 1'b1, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			for (int p = 0; p < 4; p++) begin
				u_host.access(1'b1, 2'(p), rw_code[i], {rw_code[i], 6'h00, 2'(p)}, r);
			end
		end
		for (int i = 0; i < 7; i++) begin
			for (int p = 0; p < 4; p++) begin
				u_host.access(1'b0, 2'(p), rw_code[i], 16'h0000, r);
				chk_rsp(r, 1'b1, 1'b1, {rw_code[i], 6'h00, rw_paged[i] ? 2'(p) : 2'h3});
			end
		end
		u_host.access(1'b1, 2'h2, 8'hb4, 16'h6b4d, r);
		u_host.access(1'b0, 2'h1, 8'hb4, 16'h0000, r);
		chk_rsp(r, 1'b1, 1'b1, 16'h6b4d);
		u_host.access(1'b1, 2'h1, 8'hb3, 16'h3b1e, r);
		u_host.access(1'b0, 2'h1, 8'hb3, 16'h0000, r);
		chk_rsp(r, 1'b1, 1'b1, 16'h3b1e);
	endtask : t_scratch

	task automatic ee_put(input logic [4:0] t, input logic [15:0] d);
		@(posedge core_clk);
		ee_load <= '{1'b1, t, d};
		@(posedge core_clk);
		ee_load <= '{1'b0, ~t, ~d};
	endtask : ee_put

	task automatic t_eeprom();
		ee_put(5'h0a, 16'hc3a5);
		ee_put(5'h11, 16'h77e1);
		ee_put(5'h15, 16'hdead); // bc has no eeprom copy
		u_host.access(1'b0, 2'h2, 8'hb3, 16'h0000, r);
		chk_rsp(r, 1'b1, 1'b1, 16'hc3a5);
		u_host.access(1'b1, 2'h1, 8'he8, 16'h0055, r);
		u_host.access(1'b0, 2'h1, 8'he8, 16'h0000, r);
		chk_rsp(r, 1'b1, 1'b0, 16'h00e1);
		u_host.access(1'b0, 2'h1, 8'hbc, 16'h0000, r);
		chk_rsp(r, 1'b1, 1'b1, 16'hbc01);
	endtask : t_eeprom

	task automatic t_info();
		@(posedge core_clk);
		ecc_clean <= 1'b0;
		restore_all <= 1'b1;
		// read leaves on the refresh edge, so it sees the new word at once
		fork
			u_host.access(1'b0, 2'h0, 8'hb6, 16'h0000, r);
			begin
				@(posedge core_clk);
				restore_all <= 1'b0;
			end
		join
		chk_rsp(r, 1'b1, 1'b1, 16'h0000);
		@(posedge core_clk);
		ecc_clean <= 1'b1;
		bulk_read <= 1'b1;
		fork
			u_host.access(1'b0, 2'h0, 8'hb6, 16'h0000, r);
			begin
				@(posedge core_clk);
				bulk_read <= 1'b0;
				ecc_clean <= 1'b0;
			end
		join
		chk_rsp(r, 1'b1, 1'b1, 16'h0020);
	endtask : t_info

	task automatic t_pec();
		for (int v = 1; v >= 0; v--) begin
			@(posedge core_clk);
			pec_cfg_en <= 1'(v);
			@(posedge core_clk);
			#1 chk_val({15'h0000, pec_required}, 16'(v));
			u_host.access(1'b0, 2'h0, 8'h19, 16'h0000, r);
			chk_rsp(r, 1'b1, 1'b0, 16'h00b0);
		end
	endtask : t_pec

	task automatic t_fault();
		@(posedge core_clk);
		fl_set_present <= 1'b1;
		@(posedge core_clk);
		fl_set_present <= 1'b0;
		u_host.log_read(8'hed, 8'h5a);
		chk_val({fl_byte_valid, 7'h00, fl_byte}, 16'h805a);
		u_host.log_read(8'hee, 8'h5a);
		chk_val({fl_byte_valid, 7'h00, fl_byte}, 16'h8000);
		u_host.log_read(8'hfe, 8'hff);
		chk_val({fault_log_present, 7'h00, fl_byte}, 16'h8000);
		u_host.log_read(8'hff, 8'h3c);
		chk_val({fault_log_present, 7'h00, fl_byte}, 16'h0000);
	endtask : t_fault

	initial begin
		rst = 1'b1;
		restore_all = 1'b0;
		bulk_read = 1'b0;
		ecc_clean = 1'b1;
		pec_cfg_en = 1'b0;
		fl_set_present = 1'b0;
		ee_load = '0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		t_ro(1'b0);
		t_ro(1'b1);
		t_scratch();
		t_eeprom();
		t_info();
		t_pec();
		t_fault();
		tally_and_finish();
	end

	// full sequence needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge core_clk);
		fail_count++;
		tally_and_finish();
	end
endmodule : pisr_regs_tb_top

`default_nettype wire
